// File: logic/core_clock_switch.sv
`timescale 1ns/1ps
`default_nettype none

module core_clock_switch (
	input wire logic i_core_clk,
	input wire logic i_reset,
	input wire logic i_bus_clk,
	input wire logic i_fast_core_clock_in,
	input wire clk_mode_pkg::mode_sel_t i_mode_sel,
	input wire logic i_ext_access,
	output logic o_internal_core_clock,
	output logic o_core_clock_observe_out,
	output logic o_bus_if_clock,
	output logic o_on_bus_clock,
	output clk_mode_pkg::clk_mode_t o_mode
);

	clk_mode_pkg::sw_regs_t q_ff;
	clk_mode_pkg::sw_regs_t nxt_q;
	clk_mode_pkg::clk_mode_t mode_ff;
	clk_mode_pkg::clk_mode_t nxt_mode;
	logic want_bus;
	logic bus_rise;
	logic bus_fall;
	logic fast_rise;
	logic fast_fall;

	// Decode of the two select bits
	function automatic clk_mode_pkg::clk_mode_t decode_mode(
		input clk_mode_pkg::mode_sel_t sel
	);
		if (!sel.not_bus_clocked_select)
		begin
			return clk_mode_pkg::MODE_BUS_CLOCKED;
		end
		else if (sel.async_clock_select)
		begin
			return clk_mode_pkg::MODE_ASYNC;
		end
		else
		begin
			return clk_mode_pkg::MODE_SYNC;
		end
	endfunction : decode_mode

	// Edge detection on sampled clock levels
	always_comb
	begin
		bus_rise = i_bus_clk & ~q_ff.bus_prev;
		bus_fall = ~i_bus_clk & q_ff.bus_prev;
		fast_rise = i_fast_core_clock_in & ~q_ff.fast_prev;
		fast_fall = ~i_fast_core_clock_in & q_ff.fast_prev;
		nxt_mode = decode_mode(i_mode_sel);
		want_bus = (mode_ff == clk_mode_pkg::MODE_BUS_CLOCKED) | i_ext_access;
	end

	// Glitch-free switch: source gated low between the two clocks
	always_comb
	begin
		nxt_q = q_ff;
		nxt_q.bus_prev = i_bus_clk;
		nxt_q.fast_prev = i_fast_core_clock_in;
		nxt_q.bus_if_clock = i_bus_clk;
		case (q_ff.state)
			clk_mode_pkg::ST_ON_FAST:
			begin
				nxt_q.internal_core_clock = i_fast_core_clock_in;
				// Leave only at a low level so no high pulse is cut
				if (want_bus && !i_fast_core_clock_in)
				begin
					nxt_q.state = clk_mode_pkg::ST_TO_BUS;
					nxt_q.internal_core_clock = 1'b0;
					nxt_q.seen_rise = 1'b0;
				end
			end
			clk_mode_pkg::ST_TO_BUS:
			begin
				nxt_q.internal_core_clock = 1'b0;
				if (bus_rise)
				begin
					nxt_q.seen_rise = 1'b1;
				end
				// Sync takes first bus fall, async a full bus cycle
				if (bus_fall && (mode_ff != clk_mode_pkg::MODE_ASYNC ||
					q_ff.seen_rise))
				begin
					nxt_q.state = clk_mode_pkg::ST_ON_BUS;
					nxt_q.on_bus = 1'b1;
				end
			end
			clk_mode_pkg::ST_ON_BUS:
			begin
				nxt_q.internal_core_clock = i_bus_clk;
				if (!want_bus && !i_bus_clk)
				begin
					nxt_q.state = clk_mode_pkg::ST_TO_FAST;
					nxt_q.internal_core_clock = 1'b0;
					nxt_q.seen_rise = 1'b0;
				end
			end
			clk_mode_pkg::ST_TO_FAST:
			begin
				nxt_q.internal_core_clock = 1'b0;
				if (fast_rise)
				begin
					nxt_q.seen_rise = 1'b1;
				end
				if (want_bus)
				begin
					nxt_q.state = clk_mode_pkg::ST_TO_BUS;
					nxt_q.seen_rise = 1'b0;
				end
				// Sync takes next fast fall, async a full fast cycle
				else if (fast_fall && (mode_ff != clk_mode_pkg::MODE_ASYNC ||
					q_ff.seen_rise))
				begin
					nxt_q.state = clk_mode_pkg::ST_ON_FAST;
					nxt_q.on_bus = 1'b0;
				end
			end
			default:
			begin
				nxt_q = clk_mode_pkg::SW_RESET;
			end
		endcase
		nxt_q.observe = nxt_q.internal_core_clock;
	end

	// State is plain flops; it holds while the bus and fast clocks stop, but a pending switch waits for their edges
	always_ff @(posedge i_core_clk)
	begin
		if (i_reset)
		begin
			q_ff <= clk_mode_pkg::SW_RESET;
			mode_ff <= clk_mode_pkg::MODE_BUS_CLOCKED;
		end
		else
		begin
			q_ff <= nxt_q;
			mode_ff <= nxt_mode;
		end
	end

	assign o_internal_core_clock = q_ff.internal_core_clock;
	assign o_core_clock_observe_out = q_ff.observe;
	assign o_bus_if_clock = q_ff.bus_if_clock;
	assign o_on_bus_clock = q_ff.on_bus;
	assign o_mode = mode_ff;

	// Cycle counter of a pending switch, for the checks
	logic [15:0] wait_cnt_ff;
	always_ff @(posedge i_core_clk)
	begin
		if (i_reset || q_ff.state == clk_mode_pkg::ST_ON_FAST ||
			q_ff.state == clk_mode_pkg::ST_ON_BUS)
		begin
			wait_cnt_ff <= 16'h0000;
		end
		else
		begin
			wait_cnt_ff <= wait_cnt_ff + 16'h0001;
		end
	end

	a_observe_copy: assert property (@(posedge i_core_clk) disable iff (i_reset)
		o_core_clock_observe_out == o_internal_core_clock)
		else $error("observe output differs from core clock");

	a_bus_mode_src: assert property (@(posedge i_core_clk) disable iff (i_reset)
		q_ff.state == clk_mode_pkg::ST_ON_BUS |=>
		o_internal_core_clock == $past(i_bus_clk))
		else $error("core clock not following bus clock");

	a_fast_src: assert property (@(posedge i_core_clk) disable iff (i_reset)
		(q_ff.state == clk_mode_pkg::ST_ON_FAST && !want_bus) |=>
		o_internal_core_clock == $past(i_fast_core_clock_in))
		else $error("core clock not following fast clock");

	a_mode_decode: assert property (@(posedge i_core_clk) disable iff (i_reset)
		!i_mode_sel.not_bus_clocked_select |=>
		o_mode == clk_mode_pkg::MODE_BUS_CLOCKED)
		else $error("bus-clocked mode not decoded");

	a_bus_if_clk: assert property (@(posedge i_core_clk) disable iff (i_reset)
		##1 o_bus_if_clock == $past(i_bus_clk))
		else $error("bus interface clock not from bus clock");

	a_sync_to_bus: assert property (@(posedge i_core_clk) disable iff (i_reset)
		(q_ff.state == clk_mode_pkg::ST_TO_BUS &&
		mode_ff == clk_mode_pkg::MODE_SYNC && bus_fall) |=>
		q_ff.state == clk_mode_pkg::ST_ON_BUS)
		else $error("sync switch to bus missed bus fall");

	a_async_wait: assert property (@(posedge i_core_clk) disable iff (i_reset)
		(q_ff.state == clk_mode_pkg::ST_TO_BUS &&
		mode_ff == clk_mode_pkg::MODE_ASYNC && !q_ff.seen_rise) |=>
		q_ff.state != clk_mode_pkg::ST_ON_BUS)
		else $error("async switch to bus too early");

	a_async_back: assert property (@(posedge i_core_clk) disable iff (i_reset)
		(q_ff.state == clk_mode_pkg::ST_TO_FAST &&
		mode_ff == clk_mode_pkg::MODE_ASYNC && !q_ff.seen_rise) |=>
		q_ff.state != clk_mode_pkg::ST_ON_FAST)
		else $error("async switch to fast too early");

	a_gap_low: assert property (@(posedge i_core_clk) disable iff (i_reset)
		(q_ff.state == clk_mode_pkg::ST_TO_BUS ||
		q_ff.state == clk_mode_pkg::ST_TO_FAST) |->
		!o_internal_core_clock)
		else $error("core clock high during switch gap");

	a_leave_low: assert property (@(posedge i_core_clk) disable iff (i_reset)
		$rose(q_ff.state == clk_mode_pkg::ST_TO_BUS) |->
		$past(!o_internal_core_clock || !i_fast_core_clock_in))
		else $error("fast clock cut while high");

	a_sync_back: assert property (@(posedge i_core_clk) disable iff (i_reset)
		(q_ff.state == clk_mode_pkg::ST_TO_FAST && !want_bus &&
		mode_ff == clk_mode_pkg::MODE_SYNC && fast_fall) |=>
		q_ff.state == clk_mode_pkg::ST_ON_FAST)
		else $error("sync return to fast missed fast fall");

	// Sequencer always holds exactly one state
	a_state_onehot: assert property (@(posedge i_core_clk) disable iff (i_reset)
		$onehot(q_ff.state))
		else $error("switch state not one-hot");

	// Flag high whenever the bus clock drives the core
	a_on_bus_flag: assert property (@(posedge i_core_clk) disable iff (i_reset)
		q_ff.state == clk_mode_pkg::ST_ON_BUS |->
		o_on_bus_clock)
		else $error("on-bus flag low while on bus clock");

	// Flag low whenever the fast clock drives the core
	a_off_bus_flag: assert property (@(posedge i_core_clk) disable iff (i_reset)
		q_ff.state == clk_mode_pkg::ST_ON_FAST |->
		!o_on_bus_clock)
		else $error("on-bus flag high while on fast clock");

	// Bus-clocked mode never leaves the bus clock
	a_bus_mode_hold: assert property (@(posedge i_core_clk) disable iff (i_reset)
		(q_ff.state == clk_mode_pkg::ST_ON_BUS &&
		mode_ff == clk_mode_pkg::MODE_BUS_CLOCKED) |=>
		q_ff.state == clk_mode_pkg::ST_ON_BUS)
		else $error("left bus clock in bus-clocked mode");

	// Core stays on fast clock while no access is pending and the mode is not bus-clocked
	a_stay_fast: assert property (@(posedge i_core_clk) disable iff (i_reset)
		(q_ff.state == clk_mode_pkg::ST_ON_FAST && !want_bus) |=>
		q_ff.state == clk_mode_pkg::ST_ON_FAST)
		else $error("left fast clock without access");

	// New access during return goes back towards bus
	a_fast_revert: assert property (@(posedge i_core_clk) disable iff (i_reset)
		(q_ff.state == clk_mode_pkg::ST_TO_FAST && want_bus) |=>
		q_ff.state == clk_mode_pkg::ST_TO_BUS)
		else $error("access during return not honoured");

	// Synchronous mode decode
	a_mode_sync: assert property (@(posedge i_core_clk) disable iff (i_reset)
		(i_mode_sel.not_bus_clocked_select &&
		!i_mode_sel.async_clock_select) |=>
		o_mode == clk_mode_pkg::MODE_SYNC)
		else $error("synchronous mode not decoded");

	// Asynchronous mode decode
	a_mode_async: assert property (@(posedge i_core_clk) disable iff (i_reset)
		(i_mode_sel.not_bus_clocked_select &&
		i_mode_sel.async_clock_select) |=>
		o_mode == clk_mode_pkg::MODE_ASYNC)
		else $error("asynchronous mode not decoded");

	// Wait counter restarts once a switch has settled
	a_count_clear: assert property (@(posedge i_core_clk) disable iff (i_reset)
		(q_ff.state == clk_mode_pkg::ST_ON_FAST ||
		q_ff.state == clk_mode_pkg::ST_ON_BUS) |=>
		wait_cnt_ff == 16'h0000)
		else $error("switch wait counter not cleared");

endmodule : core_clock_switch

`default_nettype wire

// File: logic/clk_mode_pkg.sv
package clk_mode_pkg;

	// Clocking mode chosen by the two select bits
	typedef enum logic [2:0] {
		MODE_BUS_CLOCKED = 3'h1,
		MODE_SYNC = 3'h2,
		MODE_ASYNC = 3'h4
	} clk_mode_t;

	// Switch-over sequencer, one-hot
	typedef enum logic [3:0] {
		ST_ON_FAST = 4'h1,
		ST_TO_BUS = 4'h2,
		ST_ON_BUS = 4'h4,
		ST_TO_FAST = 4'h8
	} sw_state_t;

	// Mode select bits as sampled
	typedef struct packed {
		logic not_bus_clocked_select;
		logic async_clock_select;
	} mode_sel_t;

	// Whole state of the switch
	typedef struct packed {
		sw_state_t state;
		logic bus_prev;
		logic fast_prev;
		logic seen_rise;
		logic internal_core_clock;
		logic observe;
		logic bus_if_clock;
		logic on_bus;
	} sw_regs_t;

	localparam sw_regs_t SW_RESET = '{
		state: ST_ON_BUS,
		bus_prev: 1'b0,
		fast_prev: 1'b0,
		seen_rise: 1'b0,
		internal_core_clock: 1'b0,
		observe: 1'b0,
		bus_if_clock: 1'b0,
		on_bus: 1'b1
	};

	// Longest waits in core clock cycles, not used by any check
	localparam int unsigned MAX_SWITCH_WAIT = 16'h0040;

endpackage : clk_mode_pkg

// File: dv/clk_source_model.sv
`timescale 1ns/1ps
`default_nettype none
module clk_source_model (
	input wire logic i_core_clk,
	input wire logic i_run,
	input wire logic i_async,
	output logic o_bus_clk,
	output logic o_fast_clk
);
	logic [7:0] cnt_ff = 8'h00;
	logic [5:0] acnt_ff = 6'h00;
	logic bus_ff = 1'b0;
	// Both clocks freeze in phase while stopped
	always @(posedge i_core_clk)
		if (i_run)
		begin
			cnt_ff <= cnt_ff + 8'h01;
			acnt_ff <= (acnt_ff == 6'h24) ? 6'h00 : acnt_ff + 6'h01;
			// Sync: bus moves mid fast high, eight fast per bus
			if (!i_async && cnt_ff[4:0] == 5'h05)
				bus_ff <= !bus_ff;
			// Async: unrelated 74 cycle bus period
			if (i_async && acnt_ff == 6'h24)
				bus_ff <= !bus_ff;
		end
	// Fast half period of four cycles
	assign o_fast_clk = cnt_ff[2];
	assign o_bus_clk = bus_ff;
endmodule : clk_source_model
`default_nettype wire

// File: dv/tb_cpu_core_clock_mode_switch.sv
`timescale 1ns/1ps
`default_nettype none
module tb_cpu_core_clock_mode_switch;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic run = 1'b1;
	logic ext = 1'b0;
	logic bus, fast, core, obs, bif, onb, prev, last;
	clk_mode_pkg::mode_sel_t sel = '0;
	clk_mode_pkg::clk_mode_t mode;
	int fail_count = 0;
	int checks = 0;
	int n;
	int len = 0;
	// Free running core clock
	initial
	begin
		forever #25 clk = ~clk;
	end
	clk_source_model i_src (.i_core_clk(clk), .i_run(run),
		.i_async(sel.async_clock_select), .o_bus_clk(bus), .o_fast_clk(fast));
	core_clock_switch i_dut (.i_core_clk(clk), .i_reset(rst), .i_bus_clk(bus),
		.i_fast_core_clock_in(fast), .i_mode_sel(sel), .i_ext_access(ext),
		.o_internal_core_clock(core), .o_core_clock_observe_out(obs),
		.o_bus_if_clock(bif), .o_on_bus_clock(onb), .o_mode(mode));
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : check
	task automatic stop_test();
		if (fail_count == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : stop_test
	task automatic step(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask : step
	function automatic logic sig(input int w);
		return w == 0 ? bus : w == 1 ? fast : w == 2 ? onb : core;
	endfunction : sig
	// Bounded wait for a level, cycles left in n
	task automatic wait_lv(input int w, input logic v, input int lim);
		n = 0;
		while (sig(w) !== v)
		begin
			step(1);
			n++;
			if (n > lim)
			begin
				fail_count++;
				stop_test();
			end
		end
	endtask : wait_lv
	task automatic range(input int lo, input int hi);
		check({7'h00, n >= lo && n <= hi}, 8'h01);
	endtask : range
	// Every level run of the core clock after the first lasts at least four cycles, one fast half period
	always @(posedge clk)
	begin
		#2;
		if (rst)
			len = -1000;
		else if (core !== last)
		begin
			if (len > 0)
				check({7'h00, len >= 4}, 8'h01);
			len = 1;
		end
		else
			len++;
		last = core;
	end
	task automatic t_bus_mode();
		step(2);
		check({5'h00, mode}, 8'h01);
		repeat (150)
		begin
			prev = bus;
			step(1);
			check({6'h00, core, obs}, {6'h00, prev, prev});
			check({6'h00, bif, onb}, {6'h00, prev, 1'b1});
		end
	endtask : t_bus_mode
	task automatic t_sync();
		sel = '{1'b1, 1'b0};
		wait_lv(2, 1'b0, 100);
		check({5'h00, mode}, 8'h02);
		repeat (32)
		begin
			prev = fast;
			step(1);
			check({7'h00, core}, {7'h00, prev});
		end
		ext = 1'b1;
		wait_lv(2, 1'b1, 100);
		range(3, 66);
		wait_lv(0, 1'b1, 80);
		wait_lv(0, 1'b0, 80);
		ext = 1'b0;
		wait_lv(2, 1'b0, 20);
		range(1, 6);
	endtask : t_sync
	task automatic t_async();
		sel = '{1'b1, 1'b1};
		step(2);
		check({5'h00, mode}, 8'h04);
		wait_lv(0, 1'b1, 100);
		wait_lv(0, 1'b0, 100);
		ext = 1'b1;
		wait_lv(2, 1'b1, 200);
		range(74, 113);
		wait_lv(1, 1'b1, 20);
		wait_lv(1, 1'b0, 20);
		ext = 1'b0;
		wait_lv(2, 1'b0, 40);
		range(8, 14);
	endtask : t_async
	task automatic t_stop();
		run = 1'b0;
		prev = core;
		step(300);
		check({6'h00, core, onb}, {6'h00, prev, 1'b0});
		run = 1'b1;
		wait_lv(3, !prev, 20);
		range(1, 12);
	endtask : t_stop
	initial
	begin
		step(3);
		check({6'h00, onb, core}, 8'h02);
		rst = 1'b0;
		t_bus_mode();
		t_sync();
		t_async();
		t_stop();
		stop_test();
	end
endmodule : tb_cpu_core_clock_mode_switch
`default_nettype wire
